// ==== src/glc_pkg.sv ====
package glc_pkg;
  // opcodes and masks of the command set
  localparam logic [7:0] OP_EXT = 8'h30;
  localparam logic [7:0] MASK_EXT = 8'hF6;
  localparam logic [7:0] MASK_BIT0 = 8'hFE;
  localparam logic [7:0] MASK_FMT = 8'hFB;
  localparam logic [7:0] OP_DISP = 8'hAE;
  localparam logic [7:0] OP_INV = 8'hA6;
  localparam logic [7:0] OP_ALLON = 8'h22;
  localparam logic [7:0] OP_DCTL = 8'hCA;
  localparam logic [7:0] OP_SLEEP = 8'h94;
  localparam logic [7:0] OP_PAGE = 8'h75;
  localparam logic [7:0] OP_COL = 8'h15;
  localparam logic [7:0] OP_SCAN = 8'hBC;
  localparam logic [7:0] OP_WRITE = 8'h5C;
  localparam logic [7:0] OP_READ = 8'h5D;
  localparam logic [7:0] OP_PIN = 8'hA8;
  localparam logic [7:0] OP_POUT = 8'hA9;
  localparam logic [7:0] OP_RMW_IN = 8'hE0;
  localparam logic [7:0] OP_RMW_OUT = 8'hEE;
  localparam logic [7:0] OP_START = 8'hAB;
  localparam logic [7:0] OP_OSC_ON = 8'hD1;
  localparam logic [7:0] OP_OSC_OFF = 8'hD2;
  localparam logic [7:0] OP_PWR = 8'h20;
  localparam logic [7:0] OP_VOP = 8'h81;
  localparam logic [7:0] OP_VSTEP = 8'hD6;
  localparam logic [7:0] OP_RDREG = 8'h7C;
  localparam logic [7:0] OP_FMT = 8'h08;
  localparam logic [7:0] OP_DMODE = 8'hF0;
  localparam logic [7:0] OP_ANALOG = 8'h32;
  localparam logic [1:0] PAGE_BASIC = 2'h0;
  localparam logic [1:0] PAGE_ANALOG = 2'h1;
  // limits and sizes
  localparam logic [7:0] PAGE_MAX = 8'h28;
  localparam logic [7:0] COL_MAX = 8'hFF;
  localparam logic [7:0] ROW_MAX = 8'hA1;
  localparam logic [8:0] VOP_MAX = 9'h1FF;
  localparam int MEM_WORDS = (int'(PAGE_MAX) + 1) * 256;
  localparam int ADDR_W = 14;
  // field positions
  localparam int B_SEL = 0;
  localparam int B_EXT_HI = 3;
  localparam int B_CLD = 2;
  localparam int B_FI = 4;
  localparam int B_LF_HI = 5;
  localparam int B_ORDER = 2;
  localparam int B_CMIR = 1;
  localparam int B_BOOST = 3;
  localparam int B_FOLLOW = 1;
  localparam int B_FMT = 2;

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } glc_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } glc_state_t;

  typedef struct packed {
    logic [1:0] page_sel;
    logic display_on;
    logic negate_pixels;
    logic force_all_lit;
    logic clock_divide_bit;
    logic [7:0] duty_count;
    logic [4:0] line_flip_count;
    logic frame_flip_type;
    logic sleep_in;
    logic [7:0] page_start;
    logic [7:0] page_end;
    logic [7:0] column_start;
    logic [7:0] column_end;
    logic scan_order;
    logic column_mirror;
    logic page_mirror;
    logic partial_on;
    logic [7:0] partial_first_row;
    logic [7:0] partial_last_row;
    logic rmw_on;
    logic [7:0] scroll_first_line;
    logic osc_on;
    logic booster_on;
    logic follower_on;
    logic regulator_on;
    logic [8:0] contrast_value_reg;
    logic read_upper;
    logic lsb_on_top;
    logic gray_mode;
    logic [1:0] booster_efficiency;
    logic [2:0] bias_ratio;
  } glc_cfg_t;

  localparam glc_cfg_t CFG_RST = '{page_end: PAGE_MAX, column_end: COL_MAX,
    partial_last_row: ROW_MAX, sleep_in: 1'b1, default: '0};
endpackage

// ==== src/glc_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for pins; first stage feeds only the second
module glc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  logic [W-1:0] meta;

  // both stages reset to the idle level of the pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      sync <= RST_VAL;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule

// ==== src/glc_buf.sv ====
`timescale 1ns/1ps
// small fifo between the bus capture and the decoder
module glc_buf #(
  parameter int W = 9,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic next_ready, push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // pointers wrap at depth; ready is registered so the pin side sees a flop
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
    next_count = count + CW'(push) - CW'(pop);
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end
    next_ready = (next_count != CW'(DEPTH));
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_ready;
    end
  end

  // storage needs no reset; count guards stale entries
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ==== src/glc_decoder.sv ====
`timescale 1ns/1ps
module glc_decoder
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hw_reset_n,
  input wire logic chip_select_n,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic cmd_data_select,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  output logic bus_ready,
  input wire logic [5:0] scan_page,
  input wire logic [7:0] scan_col,
  input wire logic [2:0] scan_bit,
  input wire logic [7:0] scan_line,
  output logic [1:0] pixel_level,
  output glc_pkg::glc_cfg_t cfg
);
  import glc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin capture
  logic [12:0] pins_s;
  logic hw_ok, cs_n_s, wr_s, rd_s, a0_s, wr_prev, rd_prev;
  logic [7:0] din_s;
  logic wr_take, rd_fall, rd_rise;
  glc_byte_t cap_b, in_b;
  logic in_valid, pop;

  glc_sync #(.W(13), .RST_VAL(13'h1FFF)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin({hw_reset_n, chip_select_n, write_strobe, read_strobe, cmd_data_select, bus_data_in}),
    .sync(pins_s)
  );
  assign {hw_ok, cs_n_s, wr_s, rd_s, a0_s, din_s} = pins_s;

  // strobe history for edge detection on the synchronised copies
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_prev <= wr_s;
      rd_prev <= rd_s;
    end
  end

  // a byte is taken on the rising edge of the write strobe while selected
  assign wr_take = wr_s && !wr_prev && !cs_n_s && hw_ok;
  assign rd_fall = !rd_s && rd_prev && !cs_n_s && hw_ok;
  assign rd_rise = rd_s && !rd_prev;
  assign cap_b = '{is_data: a0_s, value: din_s};

  // a byte offered while the buffer is full is lost; bus_ready warns the host
  glc_buf #(.W($bits(glc_byte_t)), .DEPTH(BUF_DEPTH)) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .flush(!hw_ok),
    .in_data(cap_b),
    .in_valid(wr_take),
    .in_ready(bus_ready),
    .out_data(in_b),
    .out_valid(in_valid),
    .out_ready(pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command state
  glc_state_t state, next_state;
  glc_cfg_t next_cfg;
  logic [7:0] cmd, next_cmd, cur_page, next_page, cur_col, next_col, v, v_rev;
  logic [1:0] pidx, next_pidx;
  logic fetch, next_fetch, mem_we, rd_done;
  logic [7:0] mem_wdata, mem_q;
  logic [ADDR_W-1:0] cur_addr;

  // memory address from window position, honouring the mirror bits
  function automatic logic [ADDR_W-1:0] phys(input logic [7:0] pg, input logic [7:0] col,
                                             input glc_cfg_t c);
    logic [7:0] pp, pc;
    pp = c.page_mirror ? PAGE_MAX - pg : pg;
    pc = c.column_mirror ? COL_MAX - col : col;
    return {pp[5:0], pc};
  endfunction

  // next position inside the window: the fast axis wraps, the slow one steps
  function automatic logic [15:0] step(input logic [7:0] pg, input logic [7:0] col,
                                       input glc_cfg_t c);
    logic [7:0] np, nc;
    np = pg;
    nc = col;
    if (!c.scan_order) begin
      nc = (col == c.column_end) ? c.column_start : col + 8'h01;
      if (col == c.column_end) begin
        np = (pg == c.page_end) ? c.page_start : pg + 8'h01;
      end
    end else begin
      np = (pg == c.page_end) ? c.page_start : pg + 8'h01;
      if (pg == c.page_end) begin
        nc = (col == c.column_end) ? c.column_start : col + 8'h01;
      end
    end
    return {np, nc};
  endfunction

  assign v = in_b.value;
  assign v_rev = {<<{v}}; // bit order flipped for lsb-on-top columns
  assign cur_addr = phys(cur_page, cur_col, cfg);
  // the decoder stalls while a read prefetch is under way
  assign pop = in_valid && !fetch && !rd_done;
  assign rd_done = rd_rise && bus_data_oe && a0_s && (state == ST_READ);

  // decode of commands, parameters and pixel bytes
  always_comb begin
    next_cfg = cfg;
    next_state = state;
    next_cmd = cmd;
    next_pidx = pidx;
    next_page = cur_page;
    next_col = cur_col;
    next_fetch = 1'b0;
    mem_we = 1'b0;
    mem_wdata = cfg.lsb_on_top ? v_rev : v;
    if (pop && !in_b.is_data) begin
      next_cmd = v;
      next_pidx = 2'h0;
      next_state = ST_IDLE;
      if ((v & MASK_EXT) == OP_EXT) begin
        next_cfg.page_sel = {v[B_EXT_HI], v[B_SEL]};
      end else if (cfg.page_sel == PAGE_BASIC) begin
        if ((v & MASK_BIT0) == OP_DISP) next_cfg.display_on = v[B_SEL];
        if ((v & MASK_BIT0) == OP_INV) next_cfg.negate_pixels = v[B_SEL];
        if ((v & MASK_BIT0) == OP_ALLON) next_cfg.force_all_lit = v[B_SEL];
        if ((v & MASK_BIT0) == OP_SLEEP) next_cfg.sleep_in = v[B_SEL];
        if (v == OP_POUT) next_cfg.partial_on = 1'b0;
        if (v == OP_RMW_IN) next_cfg.rmw_on = 1'b1;
        if (v == OP_RMW_OUT) next_cfg.rmw_on = 1'b0;
        if (v == OP_OSC_ON) next_cfg.osc_on = 1'b1;
        if (v == OP_OSC_OFF) next_cfg.osc_on = 1'b0;
        if ((v & MASK_BIT0) == OP_RDREG) next_cfg.read_upper = v[B_SEL];
        if ((v & MASK_FMT) == OP_FMT) next_cfg.lsb_on_top = v[B_FMT];
        if ((v & MASK_BIT0) == OP_VSTEP) begin
          if (!v[B_SEL] && cfg.contrast_value_reg != VOP_MAX) begin
            next_cfg.contrast_value_reg = cfg.contrast_value_reg + 9'h001;
          end else if (v[B_SEL] && cfg.contrast_value_reg != 9'h000) begin
            next_cfg.contrast_value_reg = cfg.contrast_value_reg - 9'h001;
          end
        end
        if (v == OP_WRITE || v == OP_READ) begin
          next_page = cfg.page_start;
          next_col = cfg.column_start;
          next_state = (v == OP_WRITE) ? ST_WRITE : ST_READ;
          next_fetch = (v == OP_READ);
        end
      end
    end else if (pop && state == ST_WRITE) begin
      mem_we = 1'b1;
      {next_page, next_col} = step(cur_page, cur_col, cfg);
    end else if (pop) begin
      next_pidx = (pidx == 2'h3) ? pidx : pidx + 2'h1;
      if (cfg.page_sel == PAGE_BASIC) begin
        case (cmd)
          OP_DCTL: begin
            if (pidx == 2'h0) next_cfg.clock_divide_bit = v[B_CLD];
            if (pidx == 2'h1) next_cfg.duty_count = v;
            if (pidx == 2'h2) begin
              next_cfg.line_flip_count = {v[B_LF_HI], v[3:0]};
              next_cfg.frame_flip_type = v[B_FI];
            end
          end
          OP_PAGE: begin
            if (pidx == 2'h0) next_cfg.page_start = v;
            if (pidx == 2'h1) next_cfg.page_end = v;
          end
          OP_COL: begin
            if (pidx == 2'h0) next_cfg.column_start = v;
            if (pidx == 2'h1) next_cfg.column_end = v;
          end
          OP_SCAN: begin
            if (pidx == 2'h0) begin
              next_cfg.scan_order = v[B_ORDER];
              next_cfg.column_mirror = v[B_CMIR];
              next_cfg.page_mirror = v[B_SEL];
            end
          end
          OP_PIN: begin
            if (pidx == 2'h0) next_cfg.partial_first_row = v;
            if (pidx == 2'h1) begin
              next_cfg.partial_last_row = v;
              next_cfg.partial_on = 1'b1;
            end
          end
          OP_START: begin
            if (pidx == 2'h0) next_cfg.scroll_first_line = v;
          end
          OP_PWR: begin
            if (pidx == 2'h0) begin
              next_cfg.booster_on = v[B_BOOST];
              next_cfg.follower_on = v[B_FOLLOW];
              next_cfg.regulator_on = v[B_SEL];
            end
          end
          OP_VOP: begin
            if (pidx == 2'h0) next_cfg.contrast_value_reg[5:0] = v[5:0];
            if (pidx == 2'h1) next_cfg.contrast_value_reg[8:6] = v[2:0];
          end
          OP_DMODE: begin
            if (pidx == 2'h0) next_cfg.gray_mode = v[B_SEL];
          end
          default: begin
          end
        endcase
      end else if (cfg.page_sel == PAGE_ANALOG && cmd == OP_ANALOG) begin
        if (pidx == 2'h1) next_cfg.booster_efficiency = v[1:0];
        if (pidx == 2'h2) next_cfg.bias_ratio = v[2:0];
      end
    end
    // read-modify-write keeps the address on reads; a later OP_WRITE still restarts at the window start
    if (rd_done) begin
      next_fetch = 1'b1;
      if (!cfg.rmw_on) begin
        {next_page, next_col} = step(cur_page, cur_col, cfg);
      end
    end
    if (!hw_ok) begin
      next_cfg = CFG_RST;
      next_state = ST_IDLE;
      next_cmd = 8'h00;
      next_pidx = 2'h0;
      next_page = 8'h00;
      next_col = 8'h00;
      next_fetch = 1'b0;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= CFG_RST;
      state <= ST_IDLE;
      cmd <= 8'h00;
      pidx <= 2'h0;
      cur_page <= 8'h00;
      cur_col <= 8'h00;
      fetch <= 1'b0;
    end else begin
      cfg <= next_cfg;
      state <= next_state;
      cmd <= next_cmd;
      pidx <= next_pidx;
      cur_page <= next_page;
      cur_col <= next_col;
      fetch <= next_fetch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display memory, one write port and a prefetch for host reads
  logic [7:0] mem [0:MEM_WORDS-1];
  logic [7:0] scan_byte;

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[cur_addr] <= mem_wdata;
    end
    if (fetch) begin
      mem_q <= mem[cur_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data path; the value is frozen at the falling read strobe
  logic next_oe;
  logic [7:0] next_dout;

  always_comb begin
    next_oe = bus_data_oe;
    next_dout = bus_data_out;
    if (rd_fall) begin
      next_oe = 1'b1;
      if (!a0_s) begin
        next_dout = {cfg.display_on, cfg.sleep_in, cfg.rmw_on, cfg.gray_mode, 2'h0, cfg.page_sel};
      end else if (state == ST_READ) begin
        next_dout = mem_q;
      end else begin
        next_dout = cfg.read_upper ? {5'h00, cfg.contrast_value_reg[8:6]}
                                   : {2'h0, cfg.contrast_value_reg[5:0]};
      end
    end
    if (rd_rise || cs_n_s || !hw_ok) begin
      next_oe = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_data_oe <= 1'b0;
      bus_data_out <= 8'h00;
    end else begin
      bus_data_oe <= next_oe;
      bus_data_out <= next_dout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel lookup for the panel scan
  logic [1:0] lvl, next_level;

  assign scan_byte = mem[{scan_page, scan_col}];

  always_comb begin
    lvl = cfg.gray_mode ? {scan_byte[{scan_bit[1:0], 1'b1}], scan_byte[{scan_bit[1:0], 1'b0}]}
                        : {2{scan_byte[scan_bit]}};
    if (cfg.negate_pixels) lvl = ~lvl;
    if (cfg.force_all_lit) lvl = 2'h3;
    next_level = lvl;
    if (!cfg.display_on || cfg.sleep_in) next_level = 2'h0;
    if (cfg.partial_on && (scan_line < cfg.partial_first_row || scan_line > cfg.partial_last_row)) begin
      next_level = 2'h0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pixel_level <= 2'h0;
    end else begin
      pixel_level <= next_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_cmd(logic [7:0] op, logic [7:0] m);
    pop && hw_ok && !in_b.is_data && cfg.page_sel == PAGE_BASIC && (in_b.value & m) == op;
  endsequence

  a_cmd_no_store: assert property (pop && !in_b.is_data |-> !mem_we)
    else $error("command byte written to memory");
  a_page_select: assert property (pop && hw_ok && !in_b.is_data && (in_b.value & MASK_EXT) == OP_EXT
    |=> cfg.page_sel == {$past(in_b.value[3]), $past(in_b.value[0])})
    else $error("page select not taken");
  a_display_switch: assert property (s_cmd(OP_DISP, MASK_BIT0) |=> cfg.display_on == $past(in_b.value[0]))
    else $error("display switch wrong");
  a_inverse_mode: assert property (s_cmd(OP_INV, MASK_BIT0) |=> cfg.negate_pixels == $past(in_b.value[0]))
    else $error("inversion wrong");
  a_sleep_mode: assert property (s_cmd(OP_SLEEP, MASK_BIT0) |=> cfg.sleep_in == $past(in_b.value[0]))
    else $error("sleep wrong");
  a_contrast_up: assert property (s_cmd(OP_VSTEP, 8'hFF) && cfg.contrast_value_reg != VOP_MAX
    |=> cfg.contrast_value_reg == $past(cfg.contrast_value_reg) + 9'h001)
    else $error("contrast step up wrong");
  a_write_entry: assert property (s_cmd(OP_WRITE, 8'hFF) |=> state == ST_WRITE
    && cur_page == $past(cfg.page_start) && cur_col == $past(cfg.column_start))
    else $error("write entry not at window start");
  a_hw_reset: assert property (!hw_ok |=> cfg == CFG_RST && state == ST_IDLE && pidx == 2'h0)
    else $error("hardware reset incomplete");
  a_col_advance: assert property (mem_we && !cfg.scan_order && cur_col != cfg.column_end
    |=> cur_col == $past(cur_col) + 8'h01)
    else $error("column did not advance");
endmodule

// ==== tb/glc_host.sv ====
`timescale 1ns/1ps
// host side of the parallel bus; write strobes hold 4 clocks and read strobes 6 so the pin synchroniser sees each level
module glc_host (
  input wire logic core_clk,
  output logic chip_select_n,
  output logic write_strobe,
  output logic read_strobe,
  output logic cmd_data_select,
  output logic [7:0] bus_data_in,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe
);
  initial begin
    chip_select_n = 1'b1;
    write_strobe = 1'b1;
    read_strobe = 1'b1;
    cmd_data_select = 1'b0;
    bus_data_in = 8'h00;
  end
  // one byte out; caller keeps window bytes legal
  task automatic wr(input logic a0, input logic [7:0] d);
    @(negedge core_clk);
    chip_select_n = 1'b0;
    cmd_data_select = a0;
    bus_data_in = d;
    write_strobe = 1'b0;
    repeat (4) @(negedge core_clk);
    write_strobe = 1'b1;
    repeat (4) @(negedge core_clk);
    bus_data_in = ~d; // a released bus must not keep the old byte
    chip_select_n = 1'b1;
  endtask
  // one read cycle, returns {oe, byte} seen while the strobe is low
  task automatic rd(input logic a0, output logic [8:0] r);
    @(negedge core_clk);
    chip_select_n = 1'b0;
    cmd_data_select = a0;
    read_strobe = 1'b0;
    repeat (6) @(negedge core_clk);
    r = {bus_data_oe, bus_data_out};
    read_strobe = 1'b1;
    repeat (6) @(negedge core_clk);
    chip_select_n = 1'b1;
  endtask
endmodule

// ==== tb/glc_decoder_tb_top.sv ====
`timescale 1ns/1ps
module glc_decoder_tb_top;
  import glc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic chip_select_n, write_strobe, read_strobe, cmd_data_select;
  logic [7:0] bus_data_in, bus_data_out;
  logic bus_data_oe, bus_ready;
  logic [1:0] pixel_level;
  logic [5:0] scan_page = 6'h00;
  logic [7:0] scan_col = 8'h00;
  logic [2:0] scan_bit = 3'h0;
  logic [8:0] r;
  glc_cfg_t cfg, exp;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 core_clk = ~core_clk;
  glc_decoder i_glc_decoder (.core_clk(core_clk), .rst(rst), .hw_reset_n(hw_reset_n),
    .chip_select_n(chip_select_n), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .cmd_data_select(cmd_data_select), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe), .bus_ready(bus_ready), .scan_page(scan_page), .scan_col(scan_col),
    .scan_bit(scan_bit), .scan_line(8'h00), .pixel_level(pixel_level), .cfg(cfg));
  glc_host i_glc_host (.core_clk(core_clk), .chip_select_n(chip_select_n), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .cmd_data_select(cmd_data_select), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_val(input string n, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // settle time covers buffer plus decode after the last byte
  task automatic chk_cfg(input glc_cfg_t e);
    repeat (3) @(negedge core_clk);
    comparisons++;
    if (cfg !== e) begin
      err_total++;
      $display("[FAIL] cfg expected %h seen %h", e, cfg);
    end
  endtask
  task automatic cmd(input logic [7:0] d);
    i_glc_host.wr(1'b0, d);
  endtask
  task automatic par(input logic [7:0] d);
    i_glc_host.wr(1'b1, d);
  endtask
  // a hang counts as a mismatch; the whole run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    exp = CFG_RST;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_cfg(exp);
    chk_val("bus_ready", 9'h001, {8'h00, bus_ready});
    cmd(8'hAF);
    cmd(8'hA7);
    cmd(8'h23);
    cmd(8'h95);
    cmd(8'h94);
    exp.display_on = 1'b1;
    exp.negate_pixels = 1'b1;
    exp.force_all_lit = 1'b1;
    exp.sleep_in = 1'b0;
    chk_cfg(exp);
    chk_val("pixel_level", 9'h003, {7'h00, pixel_level});
    cmd(8'hCA);
    par(8'h04);
    par(8'h9F);
    par(8'h35);
    cmd(8'h75);
    par(8'h02);
    par(8'h05);
    cmd(8'h15);
    par(8'h10);
    par(8'h20);
    cmd(8'hBC);
    par(8'h07);
    exp.clock_divide_bit = 1'b1;
    exp.duty_count = 8'h9F;
    exp.line_flip_count = 5'h15;
    exp.frame_flip_type = 1'b1;
    exp.page_start = 8'h02;
    exp.page_end = 8'h05;
    exp.column_start = 8'h10;
    exp.column_end = 8'h20;
    exp.scan_order = 1'b1;
    exp.column_mirror = 1'b1;
    exp.page_mirror = 1'b1;
    chk_cfg(exp);
    // column-fast order for the memory test, so the column really steps
    cmd(8'hBC);
    par(8'h03);
    exp.scan_order = 1'b0;
    chk_cfg(exp);
    // two bytes in, two back: the second proves the column stepped
    cmd(8'h5C);
    par(8'hAA);
    par(8'h55);
    cmd(8'h5D);
    repeat (4) @(negedge core_clk);
    i_glc_host.rd(1'b1, r);
    chk_val("mem0", 9'h1AA, r);
    i_glc_host.rd(1'b1, r);
    chk_val("mem1", 9'h155, r);
    i_glc_host.rd(1'b0, r);
    chk_val("status", 9'h180, r);
    cmd(8'hA8);
    par(8'h03);
    par(8'hA1);
    cmd(8'hE0);
    cmd(8'hAB);
    par(8'h12);
    cmd(8'hD1);
    cmd(8'h20);
    par(8'h0B);
    par(8'hFF); // surplus byte is ignored
    cmd(8'hD6);
    cmd(8'hD6);
    cmd(8'hD7);
    exp.partial_on = 1'b1;
    exp.partial_first_row = 8'h03;
    exp.partial_last_row = 8'hA1;
    exp.rmw_on = 1'b1;
    exp.scroll_first_line = 8'h12;
    exp.osc_on = 1'b1;
    exp.booster_on = 1'b1;
    exp.follower_on = 1'b1;
    exp.regulator_on = 1'b1;
    exp.contrast_value_reg = 9'h001;
    chk_cfg(exp);
    // scan line 0 lies above the partial area, so even all-lit stays dark
    chk_val("pixel_partial", 9'h000, {7'h00, pixel_level});
    i_glc_host.rd(1'b1, r);
    chk_val("vop_low", 9'h101, r);
    cmd(8'h7D);
    i_glc_host.rd(1'b1, r);
    chk_val("vop_high", 9'h100, r);
    cmd(8'h0C);
    cmd(8'hF0);
    par(8'h01);
    cmd(8'h31);
    cmd(8'h32);
    par(8'h00);
    par(8'h02);
    par(8'h05);
    exp.read_upper = 1'b1;
    exp.lsb_on_top = 1'b1;
    exp.gray_mode = 1'b1;
    exp.page_sel = PAGE_ANALOG;
    exp.booster_efficiency = 2'h2;
    exp.bias_ratio = 3'h5;
    chk_cfg(exp);
    cmd(8'h30);
    cmd(8'hA9);
    cmd(8'hEE);
    cmd(8'hD2);
    exp.page_sel = PAGE_BASIC;
    exp.partial_on = 1'b0;
    exp.rmw_on = 1'b0;
    exp.osc_on = 1'b0;
    chk_cfg(exp);
    // first written byte AA sits at mirrored page 26h, column EFh; gray pair 0 of AA is level 2
    cmd(8'h22);
    cmd(8'hA6);
    scan_page = 6'h26;
    scan_col = 8'hEF;
    scan_bit = 3'h0;
    repeat (3) @(negedge core_clk);
    chk_val("pixel_gray", 9'h002, {7'h00, pixel_level});
    // reset in mid-sequence; the late parameter must find no command
    cmd(8'hCA);
    par(8'h04);
    hw_reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    hw_reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    par(8'h9F);
    chk_cfg(CFG_RST);
    wrap_up();
  end
endmodule
